// file: core/bru_pkg.sv
package bru_pkg;

	// ==========================================
	// Widths and operation codes
	localparam int BRU_DW = 8;
	localparam int BRU_MSB = 7;
	localparam int BRU_LSB = 0;
	localparam logic [7:0] BRU_ACC_RST = 8'h00;
	localparam logic BRU_FLAG_RST = 1'b0;

	// One-hot operation select
	typedef enum logic [6:0] {
		BRU_OP_NONE = 7'h01,
		BRU_OP_LEFT_WORK = 7'h02,
		BRU_OP_LEFT_FLAG_MEM = 7'h04,
		BRU_OP_LEFT_FLAG_WORK = 7'h08,
		BRU_OP_RIGHT_MEM = 7'h10,
		BRU_OP_RIGHT_WORK = 7'h20,
		BRU_OP_RIGHT_FLAG_MEM = 7'h40
	} bru_op_t;

	// Request from the decoder
	typedef struct packed {
		logic valid;
		bru_op_t op;
		logic [7:0] addr;
		logic [7:0] data;
	} bru_req_t;

	// Write-back to data memory
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} bru_mem_wr_t;

endpackage

// file: core/bru_shifter.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Combinational one-bit rotator
module bru_shifter
	import bru_pkg::*;
(
	input wire logic [7:0] data_in,
	input wire logic flag_in,
	input wire logic right_in,
	input wire logic via_flag_in,
	output logic [7:0] res_out,
	output logic flag_out
);

	wire logic fill_left;
	wire logic fill_right;
	wire logic [7:0] rot_bits;

	// Fill bit is old flag or the wrapped bit
	assign fill_left = via_flag_in ? flag_in : data_in[BRU_MSB]; // RL1 RL2
	assign fill_right = via_flag_in ? flag_in : data_in[BRU_LSB]; // RL4 RL6

	// Interior bits take a neighbour by direction
	for (genvar i = BRU_LSB + 1; i < BRU_MSB; i++) begin : g_bit
		assign rot_bits[i] = right_in ? data_in[i + 1] : data_in[i - 1];
	end

	// End bits take the fill on their entry side
	assign rot_bits[BRU_MSB] = right_in ? fill_right : data_in[BRU_MSB - 1];
	assign rot_bits[BRU_LSB] = right_in ? data_in[BRU_LSB + 1] : fill_left;

	// Rotated byte and the bit shifted out
	assign res_out = rot_bits;
	assign flag_out = right_in ? data_in[BRU_LSB] : data_in[BRU_MSB]; // RL3

endmodule

`default_nettype wire

// file: core/bru_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (RL1) Left rotate into working register, no flags
// (RL2) Left through flag, write memory back
// (RL3) Left through flag into working register
// (RL4) Right rotate, write memory back
// (RL5) Right rotate into working register
// (RL6) Right through flag, write memory back
// (RL7) Byte operand, one cycle, other flags untouched
module bru_top
	import bru_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire bru_req_t req_in,
	output bru_mem_wr_t mem_wr_out,
	output logic [7:0] working_register_out,
	output logic carry_out
);

	// ==========================================
	// Decode
	// Decode results and rotator outputs
	wire logic is_left_work;
	wire logic is_lf_mem;
	wire logic is_lf_work;
	wire logic is_r_mem;
	wire logic is_r_work;
	wire logic is_rf_mem;
	wire logic go_right;
	wire logic go_flag;
	wire logic to_mem;
	wire logic to_work;
	wire logic [7:0] rot_res;
	wire logic rot_flag;

	// Per-op strobes, qualified by valid
	assign is_left_work = req_in.valid && req_in.op == BRU_OP_LEFT_WORK;
	assign is_lf_mem = req_in.valid && req_in.op == BRU_OP_LEFT_FLAG_MEM;
	assign is_lf_work = req_in.valid && req_in.op == BRU_OP_LEFT_FLAG_WORK;
	assign is_r_mem = req_in.valid && req_in.op == BRU_OP_RIGHT_MEM;
	assign is_r_work = req_in.valid && req_in.op == BRU_OP_RIGHT_WORK;
	assign is_rf_mem = req_in.valid && req_in.op == BRU_OP_RIGHT_FLAG_MEM;

	// Shared rotator controls
	assign go_right = is_r_mem || is_r_work || is_rf_mem;
	assign go_flag = is_lf_mem || is_lf_work || is_rf_mem; // RL2 RL3 RL6
	assign to_mem = is_lf_mem || is_r_mem || is_rf_mem; // RL2 RL4 RL6
	assign to_work = is_left_work || is_lf_work || is_r_work; // RL1 RL3 RL5

	// One rotator shared by all six ops
	bru_shifter u_shift (
		.data_in(req_in.data),
		.flag_in(carry_out),
		.right_in(go_right),
		.via_flag_in(go_flag),
		.res_out(rot_res),
		.flag_out(rot_flag)
	);

	// ==========================================
	// State
	// Next values and registered state
	logic [7:0] nxt_acc;
	logic nxt_carry;
	bru_mem_wr_t nxt_mem;
	logic [7:0] acc_ff;
	logic carry_ff;
	bru_mem_wr_t mem_ff;

	// Next values, single cycle completion
	assign nxt_acc = to_work ? rot_res : acc_ff; // RL1 RL3 RL5
	assign nxt_carry = go_flag ? rot_flag : carry_ff; // RL2 RL3 RL6
	assign nxt_mem = '{wr: to_mem, addr: req_in.addr, data: rot_res}; // RL7

	// Registers
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acc_ff <= BRU_ACC_RST;
			carry_ff <= BRU_FLAG_RST;
			mem_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
			carry_ff <= nxt_carry;
			mem_ff <= nxt_mem;
		end
	end

	// Outputs straight from the registers
	assign working_register_out = acc_ff;
	assign carry_out = carry_ff;
	assign mem_wr_out = mem_ff;

	// ==========================================
	// Checks

	// Left rotate to working: byte wraps, no write, carry held
	sequence left_work_done_s;
		!mem_wr_out.wr && $stable(carry_out) &&
			working_register_out ==
			{$past(req_in.data[6:0]), $past(req_in.data[7])};
	endsequence

	// Left through carry in place: old carry enters bit 0
	sequence left_flag_mem_done_s;
		mem_wr_out.wr && $stable(working_register_out) &&
			mem_wr_out.data == {$past(req_in.data[6:0]), $past(carry_out)} &&
			carry_out == $past(req_in.data[7]);
	endsequence

	// Left through carry to working: memory left alone
	sequence left_flag_work_done_s;
		!mem_wr_out.wr && carry_out == $past(req_in.data[7]) &&
			working_register_out ==
			{$past(req_in.data[6:0]), $past(carry_out)};
	endsequence

	// Right rotate in place: bit 0 wraps to bit 7
	sequence right_mem_done_s;
		mem_wr_out.wr && $stable(carry_out) &&
			$stable(working_register_out) &&
			mem_wr_out.data ==
			{$past(req_in.data[0]), $past(req_in.data[7:1])};
	endsequence

	// Right rotate to working: memory and carry held
	sequence right_work_done_s;
		!mem_wr_out.wr && $stable(carry_out) &&
			working_register_out ==
			{$past(req_in.data[0]), $past(req_in.data[7:1])};
	endsequence

	// Right through carry in place: old carry enters bit 7
	sequence right_flag_mem_done_s;
		mem_wr_out.wr && $stable(working_register_out) &&
			carry_out == $past(req_in.data[0]) &&
			mem_wr_out.data ==
			{$past(carry_out), $past(req_in.data[7:1])};
	endsequence

	// Nothing taken: no write, working register and carry held
	sequence nothing_done_s;
		!mem_wr_out.wr && $stable(carry_out) &&
			$stable(working_register_out);
	endsequence

	// In-place op followed by an idle cycle
	sequence lone_mem_op_s;
		to_mem ##1 !req_in.valid;
	endsequence

	// Write strobe up for one cycle, then down
	sequence write_pulse_s;
		mem_wr_out.wr ##1 !mem_wr_out.wr;
	endsequence

	// Reset held across two edges
	sequence held_reset_s;
		!rst_b_in ##1 !rst_b_in;
	endsequence

	// One check per rotate kind
	left_work_a: assert property (@(posedge ref_clk_in) // RL1
		disable iff (!rst_b_in) is_left_work |=> left_work_done_s)
		else $error("left rotate to working wrong");
	left_flag_mem_a: assert property (@(posedge ref_clk_in) // RL2
		disable iff (!rst_b_in) is_lf_mem |=> left_flag_mem_done_s)
		else $error("left via flag in place wrong");
	left_flag_work_a: assert property (@(posedge ref_clk_in) // RL3
		disable iff (!rst_b_in) is_lf_work |=> left_flag_work_done_s)
		else $error("left via flag to working wrong");
	right_mem_a: assert property (@(posedge ref_clk_in) // RL4
		disable iff (!rst_b_in) is_r_mem |=> right_mem_done_s)
		else $error("right rotate in place wrong");
	right_work_a: assert property (@(posedge ref_clk_in) // RL5
		disable iff (!rst_b_in) is_r_work |=> right_work_done_s)
		else $error("right rotate to working wrong");
	right_flag_mem_a: assert property (@(posedge ref_clk_in) // RL6
		disable iff (!rst_b_in) is_rf_mem |=> right_flag_mem_done_s)
		else $error("right via flag in place wrong");

	// Idle or refused requests write nothing and leave working register and carry alone
	idle_quiet_a: assert property (@(posedge ref_clk_in) // RL7
		disable iff (!rst_b_in) !req_in.valid |=> nothing_done_s)
		else $error("state changed while idle");
	no_op_quiet_a: assert property (@(posedge ref_clk_in) // RL7
		disable iff (!rst_b_in) !to_mem && !to_work |=> nothing_done_s)
		else $error("state changed on refused op");

	// Working register only moves on working-register ops
	mem_only_a: assert property (@(posedge ref_clk_in) // RL7
		disable iff (!rst_b_in) to_mem |=> $stable(working_register_out))
		else $error("working register touched on in-place op");
	acc_source_a: assert property (@(posedge ref_clk_in) // RL2
		disable iff (!rst_b_in)
		$changed(working_register_out) |-> $past(to_work))
		else $error("working register changed without an op");

	// Carry only moves on flag ops
	carry_kept_a: assert property (@(posedge ref_clk_in) // RL1
		disable iff (!rst_b_in) !go_flag |=> $stable(carry_out))
		else $error("carry changed on a plain rotate");

	// Memory write: address echo, source and one-cycle strobe
	write_addr_a: assert property (@(posedge ref_clk_in) // RL4
		disable iff (!rst_b_in)
		to_mem |=> mem_wr_out.addr == $past(req_in.addr))
		else $error("write address differs from request");
	wr_source_a: assert property (@(posedge ref_clk_in) // RL3
		disable iff (!rst_b_in) mem_wr_out.wr |-> $past(to_mem))
		else $error("memory written without in-place op");
	write_pulse_a: assert property (@(posedge ref_clk_in) // RL7
		disable iff (!rst_b_in) lone_mem_op_s |-> write_pulse_s)
		else $error("write strobe not a single cycle");

	// Reset clears outputs while held
	reset_clear_a: assert property (@(posedge ref_clk_in) // RL7
		held_reset_s |-> !mem_wr_out.wr && carry_out == BRU_FLAG_RST &&
		working_register_out == BRU_ACC_RST)
		else $error("outputs not cleared in reset");

endmodule

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the rotate unit
module testbench
	import bru_pkg::*;
;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	bru_req_t req_in = '0;
	bru_mem_wr_t mem_wr;
	logic [7:0] acc;
	logic carry;
	int err_count = 0;
	int n_compared = 0;

	bru_top i_dut (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.req_in(req_in),
		.mem_wr_out(mem_wr),
		.working_register_out(acc),
		.carry_out(carry)
	);

	// Clock of 8 ns
	always #4 ref_clk_in = ~ref_clk_in;

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One request, outputs judged one cycle later
	task automatic run(input logic v, input bru_op_t op,
		input logic [7:0] d, input logic w, input logic [7:0] m,
		input logic [7:0] a, input logic c);
		req_in = {v, op, d ^ 8'h5a, d};
		@(posedge ref_clk_in);
		#1;
		chk("wr", {7'h0, w}, {7'h0, mem_wr.wr});
		if (w) begin
			chk("mem", m, mem_wr.data);
			chk("addr", d ^ 8'h5a, mem_wr.addr);
		end
		chk("acc", a, acc);
		chk("carry", {7'h0, c}, {7'h0, carry});
	endtask

	// Scenarios, back to back within each
	task automatic t_left;
		run(1, BRU_OP_LEFT_WORK, 8'h81, 0, 0, 8'h03, 0);
		run(1, BRU_OP_LEFT_FLAG_MEM, 8'h80, 1, 8'h00, 8'h03, 1);
		run(1, BRU_OP_LEFT_FLAG_WORK, 8'h41, 0, 0, 8'h83, 0);
		run(1, BRU_OP_LEFT_FLAG_MEM, 8'h7f, 1, 8'hfe, 8'h83, 0);
	endtask

	task automatic t_right;
		run(1, BRU_OP_RIGHT_MEM, 8'h01, 1, 8'h80, 8'h83, 0);
		run(1, BRU_OP_RIGHT_WORK, 8'h02, 0, 0, 8'h01, 0);
		run(1, BRU_OP_LEFT_FLAG_MEM, 8'h80, 1, 8'h00, 8'h01, 1);
		run(1, BRU_OP_RIGHT_FLAG_MEM, 8'h01, 1, 8'h80, 8'h01, 1);
		run(1, BRU_OP_RIGHT_FLAG_MEM, 8'h02, 1, 8'h81, 8'h01, 0);
	endtask

	task automatic t_refuse;
		run(0, BRU_OP_LEFT_WORK, 8'hff, 0, 0, 8'h01, 0);
		run(1, BRU_OP_NONE, 8'hff, 0, 0, 8'h01, 0);
		run(1, bru_op_t'(7'h03), 8'hff, 0, 0, 8'h01, 0);
	endtask

	// Reset in mid-run clears state with a request held
	task automatic t_reset;
		run(1, BRU_OP_LEFT_FLAG_WORK, 8'hc0, 0, 0, 8'h80, 1);
		rst_b_in = 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1;
		chk("rst wr", 8'h00, {7'h0, mem_wr.wr});
		chk("rst acc", 8'h00, acc);
		chk("rst carry", 8'h00, {7'h0, carry});
		rst_b_in = 1'b1;
		run(1, BRU_OP_RIGHT_FLAG_MEM, 8'h01, 1, 8'h00, 8'h00, 1);
		run(1, BRU_OP_LEFT_WORK, 8'h40, 0, 0, 8'h80, 1);
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk_in);
		#1;
		rst_b_in = 1'b1;
		chk("acc", 8'h00, acc);
		chk("carry", 8'h00, {7'h0, carry});
		t_left();
		t_right();
		t_refuse();
		t_reset();
		close_out();
	end

	// Watchdog, several times the expected run length
	initial begin
		#2000;
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
